// ### hw/arss_pkg.sv
// Purpose: Constants for the converter result and sleep-start control block
// Assumes: 50 MHz system clock, converter clock as a prescaled enable
// Notes:   Shared by the control block and its result formatter
//
// How it works
// RULE1: Single-ended input above reference saturates at all-ones code 0x3FF.
// RULE2: Reference select offers analog supply, internal 2.56V, or external pin.
// RULE3: Software should discard the first result after changing reference.
// RULE4: Before quiet sleep software enables converter, idle, single mode, irq on.
// RULE5: Entering noise-reduction or idle sleep starts conversion once CPU halts.
// RULE6: Done interrupt wakes the CPU if nothing else woke it first.
// RULE7: Other wake first: conversion continues, done request still raised.
// RULE8: Converter stays enabled in other sleep modes; only software disables it.
// RULE9: After done flag sets, result readable from low and high bytes.
// RULE10: Single-ended code is Vin*1024/Vref, 0x000 ground, 0x3FF top.
// RULE11: Differential code is two's complement -512..+511, saturating at limits.
// RULE12: Bit 9 in the high byte is the sign, one meaning negative.
// RULE13: Same channel may be routed to both differential inputs.
// RULE14: Shared analog pins used as outputs must not toggle during conversion.
// RULE15: Completion writes both result bytes and sets done flag together.
// RULE16: Left-justify select moves result immediately, else right adjusted.
// RULE17: Right adjusted high byte holds bits 9:8 low, upper six zero.
package arss_pkg;
	// ==========================================
	// Reference encodings
	localparam logic [1:0] REF_EXTERNAL = 2'h0;
	localparam logic [1:0] REF_SUPPLY   = 2'h1;
	localparam logic [1:0] REF_RESERVED = 2'h2;
	localparam logic [1:0] REF_INT_2V56 = 2'h3;
	// ==========================================
	// Sleep mode encodings
	localparam logic [2:0] SLEEP_IDLE   = 3'h0;
	localparam logic [2:0] SLEEP_NOISE  = 3'h1;
	// ==========================================
	// Result codes and timing
	localparam logic [9:0] CODE_MAX     = 10'h03FF;
	localparam logic [9:0] DIFF_MAX     = 10'h01FF;
	localparam logic [9:0] DIFF_MIN     = 10'h0200;
	localparam int         CONV_CYCLES  = 13;
	localparam int         FIRST_CYCLES = 25;
	localparam logic [4:0] CONV_CNT     = 5'(CONV_CYCLES);
	localparam logic [4:0] FIRST_CNT    = 5'(FIRST_CYCLES);
	localparam logic [6:0] PRESCALE_DIV = 7'h02;
	localparam int         RESET_BYTE   = 0;
	localparam logic [7:0] BYTE_ZERO    = 8'h00;
	localparam logic [5:0] HIGH_PAD     = 6'h00;
endpackage

// ### hw/arss_format.sv
// Purpose: Presents a 10-bit result across two result bytes
// Assumes: Result held in flip-flops by the caller
// Notes:   Purely combinational so justify changes act at once
`timescale 1ns/1ps
module arss_format (
	input  wire logic [9:0] result,
	input  wire logic       left_justify,
	output logic      [7:0] low_byte,
	output logic      [7:0] high_byte
);
	// ==========================================
	// Justify select
	wire [7:0] left_low   = {result[1:0], arss_pkg::HIGH_PAD};
	wire [7:0] left_high  = result[9:2];
	wire [7:0] right_low  = result[7:0];
	wire [7:0] right_high = {arss_pkg::HIGH_PAD, result[9:8]}; // [RULE17]
	assign low_byte  = left_justify ? left_low : right_low;     // [RULE16]
	assign high_byte = left_justify ? left_high : right_high;   // [RULE16]
endmodule // arss_format

// ### hw/arss_ctrl.sv
// Purpose: Converter start, sleep-start, completion and result control
// Assumes: Analog core returns a raw signed or unsigned sample on done
// Notes:   Analog sample arrives as a pin-level bus, so it is synchronised
`timescale 1ns/1ps
module arss_ctrl (
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        CONVERTER_ENABLE,
	input  wire logic        START_WRITE,
	input  wire logic        SINGLE_MODE,
	input  wire logic        IRQ_ENABLE,
	input  wire logic        DONE_FLAG_CLEAR,
	input  wire logic [1:0]  REFERENCE_SELECT,
	input  wire logic        LEFT_JUSTIFY_SELECT,
	input  wire logic [4:0]  POS_CHANNEL_SELECT,
	input  wire logic [4:0]  NEG_CHANNEL_SELECT,
	input  wire logic        DIFFERENTIAL,
	input  wire logic        SLEEP_ENTER,
	input  wire logic [2:0]  SLEEP_MODE,
	input  wire logic        CPU_HALTED,
	input  wire logic        OTHER_WAKE,
	input  wire logic [11:0] ANALOG_SAMPLE,
	output logic [1:0]       REF_SOURCE,
	output logic [4:0]       MUX_POS,
	output logic [4:0]       MUX_NEG,
	output logic             CONVERTING,
	output logic             SAMPLE_HOLD,
	output logic             CONVERSION_DONE_FLAG,
	output logic             IRQ_REQUEST,
	output logic             WAKE_CPU,
	output logic             REF_CHANGED,
	output logic [7:0]       RESULT_LOW_BYTE,
	output logic [7:0]       RESULT_HIGH_BYTE
);
	typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_ARMED, ST_CONV} arss_state_t;
	arss_state_t state;
	arss_state_t next_state;
	logic [6:0]  pre_cnt;
	logic [4:0]  cyc_cnt;
	logic        first_pending;
	logic        sleep_conv;
	logic        woke_other;
	logic [9:0]  result;
	logic [1:0]  last_ref;
	logic [11:0] samp_meta;
	logic [11:0] samp_sync;
	// ==========================================
	// Converter clock enable from divider
	wire adc_tick = (pre_cnt == arss_pkg::PRESCALE_DIV);
	// ==========================================
	// Start decode
	wire quiet_mode = (SLEEP_MODE == arss_pkg::SLEEP_IDLE) ||
	                  (SLEEP_MODE == arss_pkg::SLEEP_NOISE);
	// Arming only in quiet modes; other modes leave converter as is
	wire sleep_arm  = SLEEP_ENTER && quiet_mode && SINGLE_MODE &&
	                  IRQ_ENABLE && (state == ST_IDLE);  // [RULE5] [RULE8]
	wire sleep_go   = (state == ST_ARMED) && CPU_HALTED; // [RULE5]
	wire user_go    = (state == ST_IDLE) && START_WRITE;
	wire last_cycle = adc_tick && (cyc_cnt == 5'h01);
	wire finish     = (state == ST_CONV) && last_cycle;
	wire conv_len_ok = first_pending;
	wire [4:0] start_len = conv_len_ok ? arss_pkg::FIRST_CNT
	                                   : arss_pkg::CONV_CNT;
	// ==========================================
	// Result coding with saturation
	wire signed [11:0] s_raw  = samp_sync;
	wire               d_hi   = s_raw > $signed({2'h0, arss_pkg::DIFF_MAX});
	wire               d_lo   = s_raw < $signed({2'h3, arss_pkg::DIFF_MIN});
	wire [9:0] diff_code = d_hi ? arss_pkg::DIFF_MAX :
	                       d_lo ? arss_pkg::DIFF_MIN :
	                       samp_sync[9:0];                         // [RULE11] [RULE12]
	wire [9:0] se_code   = (samp_sync[11:10] != 2'h0) ? arss_pkg::CODE_MAX
	                                                 : samp_sync[9:0]; // [RULE1] [RULE10]
	wire [9:0] next_result = DIFFERENTIAL ? diff_code : se_code;
	// Supply, 2.56V and external pass through; reserved code maps to 2.56V
	wire [1:0] ref_eff = (REFERENCE_SELECT == arss_pkg::REF_RESERVED) ?
	                     arss_pkg::REF_INT_2V56 : REFERENCE_SELECT; // [RULE2]
	// ==========================================
	// State decode
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF:   if (CONVERTER_ENABLE) next_state = ST_IDLE;
			ST_IDLE:  if (user_go) next_state = ST_CONV;
			          else if (sleep_arm) next_state = ST_ARMED;
			ST_ARMED: if (sleep_go) next_state = ST_CONV;
			ST_CONV:  if (finish) next_state = ST_IDLE;
			default:  next_state = ST_OFF;
		endcase
		if (!CONVERTER_ENABLE) next_state = ST_OFF;
	end
	// ==========================================
	// Synchroniser for analog sample bus
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			samp_meta <= 12'h000;
			samp_sync <= 12'h000;
		end else begin
			samp_meta <= ANALOG_SAMPLE;
			samp_sync <= samp_meta;
		end
	end
	// ==========================================
	// Sequencer
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state         <= ST_OFF;
			pre_cnt       <= 7'h00;
			cyc_cnt       <= 5'h00;
			first_pending <= 1'b1;
			sleep_conv    <= 1'b0;
			woke_other    <= 1'b0;
		end else begin
			state   <= next_state;
			pre_cnt <= adc_tick ? 7'h00 : pre_cnt + 7'h01;
			if (!CONVERTER_ENABLE) begin
				first_pending <= 1'b1;
			end else if ((user_go || sleep_go) && state != ST_CONV) begin
				cyc_cnt       <= start_len;
				first_pending <= 1'b0;
				sleep_conv    <= sleep_go;
				woke_other    <= 1'b0;
			end else if (state == ST_CONV && adc_tick) begin
				cyc_cnt <= cyc_cnt - 5'h01;
			end
			// Conversion keeps running after a foreign wake-up
			if (state == ST_CONV && sleep_conv && OTHER_WAKE)
				woke_other <= 1'b1; // [RULE7]
		end
	end
	// ==========================================
	// Result and selections locked while converting; done flag set on finish, cleared by DONE_FLAG_CLEAR in any cycle without a finish
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			result               <= 10'h000;
			CONVERSION_DONE_FLAG <= 1'b0;
			WAKE_CPU             <= 1'b0;
			REF_SOURCE           <= arss_pkg::REF_EXTERNAL;
			MUX_POS              <= 5'h00;
			MUX_NEG              <= 5'h00;
			last_ref             <= arss_pkg::REF_EXTERNAL;
			REF_CHANGED          <= 1'b0;
		end else begin
			if (finish) begin
				result               <= next_result;  // [RULE15] [RULE9]
				CONVERSION_DONE_FLAG <= 1'b1;         // [RULE15]
			end else if (DONE_FLAG_CLEAR) begin
				CONVERSION_DONE_FLAG <= 1'b0;
			end
			// Wake pulse only when the conversion itself ends the sleep
			WAKE_CPU <= finish && sleep_conv && !woke_other &&
			            !OTHER_WAKE;                   // [RULE6]
			// Selections follow input except while converting
			if (state != ST_CONV || last_cycle) begin
				REF_SOURCE <= ref_eff;                 // [RULE2]
				MUX_POS    <= POS_CHANNEL_SELECT;      // [RULE13]
				MUX_NEG    <= NEG_CHANNEL_SELECT;      // [RULE13]
			end
			// Marks the next result as suspect for software
			if (finish) begin
				REF_CHANGED <= (last_ref != REF_SOURCE); // [RULE3]
				last_ref    <= REF_SOURCE;
			end
		end
	end
	// ==========================================
	// Outputs
	assign CONVERTING  = (state == ST_CONV);
	assign SAMPLE_HOLD = CONVERTING && (cyc_cnt == start_len);
	assign IRQ_REQUEST = CONVERSION_DONE_FLAG && IRQ_ENABLE; // [RULE6] [RULE7]
	arss_format u_format (
		.result       (result),
		.left_justify (LEFT_JUSTIFY_SELECT),
		.low_byte     (RESULT_LOW_BYTE),
		.high_byte    (RESULT_HIGH_BYTE)
	);
endmodule // arss_ctrl

// ### sim/arss_sva.sv
// Purpose: Port-level checks for the converter control block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every instance of the control block
`timescale 1ns/1ps
module arss_sva (
	input wire logic       CLK,
	input wire logic       RSTN,
	input wire logic       START_WRITE,
	input wire logic       CPU_HALTED,
	input wire logic       IRQ_ENABLE,
	input wire logic       DONE_FLAG_CLEAR,
	input wire logic       LEFT_JUSTIFY_SELECT,
	input wire logic       CONVERTING,
	input wire logic       SAMPLE_HOLD,
	input wire logic       CONVERSION_DONE_FLAG,
	input wire logic       IRQ_REQUEST,
	input wire logic       WAKE_CPU,
	input wire logic [1:0] REF_SOURCE,
	input wire logic [7:0] RESULT_LOW_BYTE,
	input wire logic [7:0] RESULT_HIGH_BYTE
);
	// ====================
	// Length window: start phase against the divider adds up to one tick
	localparam int TICK      = int'(arss_pkg::PRESCALE_DIV) + 1;
	localparam int SHORT_MAX = TICK * arss_pkg::CONV_CYCLES;
	localparam int SHORT_MIN = SHORT_MAX - TICK + 1;
	localparam int LONG_MAX  = TICK * arss_pkg::FIRST_CYCLES;
	localparam int LONG_MIN  = LONG_MAX - TICK + 1;
	localparam int HOLD_MAX  = TICK;
	logic [7:0] conv_len;
	logic [7:0] hold_len;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			conv_len <= 8'h00;
			hold_len <= 8'h00;
		end else if (CONVERTING) begin
			conv_len <= conv_len + 8'h01;
			hold_len <= hold_len + {7'h00, SAMPLE_HOLD};
		end else begin
			conv_len <= 8'h00;
			hold_len <= 8'h00;
		end
	end
	// ====================
	// Result seen through either justification
	wire logic [9:0] res = LEFT_JUSTIFY_SELECT ?
		{RESULT_HIGH_BYTE, RESULT_LOW_BYTE[7:6]} :
		{RESULT_HIGH_BYTE[1:0], RESULT_LOW_BYTE};
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	irq_pair_a: assert property (IRQ_REQUEST ==
		(CONVERSION_DONE_FLAG && IRQ_ENABLE)) else $error("irq mismatch");
	done_edge_a: assert property ($rose(CONVERSION_DONE_FLAG) |->
		$past(CONVERTING) && !CONVERTING) else $error("flag without end");
	flag_hold_a: assert property (CONVERSION_DONE_FLAG &&
		!DONE_FLAG_CLEAR |=> CONVERSION_DONE_FLAG) else $error("flag lost");
	start_cause_a: assert property ($rose(CONVERTING) |->
		$past(START_WRITE) || $past(CPU_HALTED)) else $error("stray start");
	wake_pulse_a: assert property (WAKE_CPU |=> !WAKE_CPU)
		else $error("wake too long");
	right_pad_a: assert property (!LEFT_JUSTIFY_SELECT |->
		RESULT_HIGH_BYTE[7:2] == 6'h00) else $error("high pad");
	left_pad_a: assert property (LEFT_JUSTIFY_SELECT |->
		RESULT_LOW_BYTE[5:0] == 6'h00) else $error("low pad");
	result_keep_a: assert property ((CONVERTING || !$past(CONVERTING)) |->
		res == $past(res)) else $error("result moved");
	ref_freeze_a: assert property (CONVERTING && $past(CONVERTING) |->
		$stable(REF_SOURCE)) else $error("reference moved");
	conv_time_a: assert property ($rose(CONVERSION_DONE_FLAG) |->
		conv_len inside {[SHORT_MIN:SHORT_MAX], [LONG_MIN:LONG_MAX]})
		else $error("conversion length");
	hold_once_a: assert property ($rose(CONVERSION_DONE_FLAG) |->
		hold_len inside {[1:HOLD_MAX]}) else $error("hold window");
	flag_clear_a: assert property (DONE_FLAG_CLEAR && !CONVERTING |=>
		!CONVERSION_DONE_FLAG) else $error("flag not cleared");
	cover property ($rose(WAKE_CPU));
	cover property ($rose(CONVERSION_DONE_FLAG) && LEFT_JUSTIFY_SELECT);
	cover property ($rose(CONVERTING) && CPU_HALTED);
	cover property ($rose(CONVERSION_DONE_FLAG) && !IRQ_ENABLE);
endmodule // arss_sva
bind arss_ctrl arss_sva u_sva (
	.CLK                  (CLK),
	.RSTN                 (RSTN),
	.START_WRITE          (START_WRITE),
	.CPU_HALTED           (CPU_HALTED),
	.IRQ_ENABLE           (IRQ_ENABLE),
	.DONE_FLAG_CLEAR      (DONE_FLAG_CLEAR),
	.LEFT_JUSTIFY_SELECT  (LEFT_JUSTIFY_SELECT),
	.CONVERTING           (CONVERTING),
	.SAMPLE_HOLD          (SAMPLE_HOLD),
	.CONVERSION_DONE_FLAG (CONVERSION_DONE_FLAG),
	.IRQ_REQUEST          (IRQ_REQUEST),
	.WAKE_CPU             (WAKE_CPU),
	.REF_SOURCE           (REF_SOURCE),
	.RESULT_LOW_BYTE      (RESULT_LOW_BYTE),
	.RESULT_HIGH_BYTE     (RESULT_HIGH_BYTE)
);

// ### sim/arss_cpu_model.sv
// Purpose: CPU sleep controller and analog source model
// Assumes: CPU clock stops the edge after a sleep command
// Notes:   Analog level only moves while the converter is idle
`timescale 1ns/1ps
module arss_cpu_model (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        sleep,
	input  wire logic        wake,
	input  wire logic        other,
	input  wire logic        busy,
	input  wire logic [11:0] level,
	output logic             halted,
	output logic      [11:0] sample
);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			halted <= 1'b0;
			sample <= 12'h000;
		end else begin
			if (sleep)
				halted <= 1'b1;
			else if (wake || other)
				halted <= 1'b0;
			if (!busy)
				sample <= level;
		end
	end
endmodule // arss_cpu_model

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: One conversion in flight at a time
// Notes:   Expected bytes queued by the driver, checked by a watcher
`timescale 1ns/1ps
`define CHK(a,b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module tb_top;
	logic clk = 0, rstn = 0, en = 0, sw = 0, dfc = 0, lj = 0, dif = 0;
	logic se = 0, ow = 0, fd = 0, halt, conv, flag, irq, wake;
	logic sgl = 1, ie = 1, rch;
	logic [1:0] rs = 0, rsrc, pr = 0;
	logic [2:0] sm = 0;
	logic [4:0] ch = 0, mp, mn;
	logic [11:0] smp = 0, asmp;
	logic [7:0] lo, hi;
	logic [15:0] q[$], seed = 16'h13AC;
	int num_errors = 0, n_checks = 0, n;
	always #10 clk = ~clk;
	arss_ctrl u_dut (.CLK(clk), .RSTN(rstn), .CONVERTER_ENABLE(en),
		.START_WRITE(sw), .SINGLE_MODE(sgl), .IRQ_ENABLE(ie),
		.DONE_FLAG_CLEAR(dfc), .REFERENCE_SELECT(rs),
		.LEFT_JUSTIFY_SELECT(lj), .POS_CHANNEL_SELECT(ch),
		.NEG_CHANNEL_SELECT(ch), .DIFFERENTIAL(dif), .SLEEP_ENTER(se),
		.SLEEP_MODE(sm), .CPU_HALTED(halt), .OTHER_WAKE(ow),
		.ANALOG_SAMPLE(asmp), .REF_SOURCE(rsrc), .MUX_POS(mp),
		.MUX_NEG(mn), .CONVERTING(conv), .SAMPLE_HOLD(),
		.CONVERSION_DONE_FLAG(flag), .IRQ_REQUEST(irq), .WAKE_CPU(wake),
		.REF_CHANGED(rch), .RESULT_LOW_BYTE(lo), .RESULT_HIGH_BYTE(hi));
	arss_cpu_model u_cpu (.clk(clk), .rstn(rstn), .sleep(se), .wake(wake),
		.other(ow), .busy(conv), .level(smp), .halted(halt), .sample(asmp));
	// ====================
	// Watcher: compare on each new completion
	always @(negedge clk) begin
		if (flag && !fd) `CHK({hi, lo}, q.pop_front())
		fd = flag;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Modes: 0 start, 1 idle sleep, 2 quiet sleep, 3 other wake, 4 deep sleep
	// 5 quiet sleep refused: single mode and done interrupt both off
	task automatic run(input logic [11:0] s, input logic d, l,
		input logic [1:0] r, input int m);
		logic [9:0] e;
		logic [1:0] re;
		int i, wk;
		e = !d ? (s[11:10] != 0 ? 10'h3FF : s[9:0]) :
			($signed(s) > 511 ? 10'h1FF :
			$signed(s) < -512 ? 10'h200 : s[9:0]);
		re = (r == 2'h2) ? 2'h3 : r;
		q.push_back(l ? {e, 6'h00} : {6'h00, e});
		@(posedge clk) begin smp <= s; dif <= d; lj <= l; rs <= r;
			sgl <= (m != 5);
			ie <= (m != 5);
			ch <= s[4:0]; sm <= m == 4 ? 3'h2 : m == 1 ? 3'h0 : 3'h1; end
		@(posedge clk) begin sw <= (m == 0); se <= (m > 0); end
		@(posedge clk) begin sw <= 0; se <= 0; end
		if (m >= 4) begin
			repeat (3) @(negedge clk);
			`CHK(conv, 1'b0)
			@(posedge clk) sw <= 1;
			@(posedge clk) sw <= 0;
		end
		wk = 0;
		for (i = 0; i < 300 && !flag; i++) begin
			@(posedge clk) ow <= (m == 3 && i == 10);
			@(negedge clk) wk += wake;
		end
		if (!flag) begin num_errors++; test_done; end
		repeat (3) begin @(negedge clk); wk += wake; end
		`CHK(wk, int'(m == 1 || m == 2))
		`CHK(irq, (m != 5))
		`CHK(rsrc, re)
		`CHK(rch, (re != pr))
		pr = re;
		`CHK({mp, mn}, {s[4:0], s[4:0]})
		@(posedge clk) begin lj <= !l; dfc <= 1; end
		@(posedge clk) dfc <= 0;
		@(negedge clk) `CHK({hi, lo}, !l ? {e, 6'h00} : {6'h00, e})
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1;
		@(posedge clk) en <= 1;
		@(posedge clk);
		run(12'h7FF, 1, 0, 0, 0);
		run(12'h800, 1, 1, 1, 1);
		run(12'hC00, 0, 0, 2, 2);
		run(12'h000, 0, 1, 3, 4);
		run(12'hE70, 1, 1, 3, 3);
		run(12'h1FF, 0, 0, 1, 5);
		for (n = 0; n < 6; n++) begin
			seed = lfsr(seed);
			run(seed[11:0], seed[12], seed[13], seed[15:14], n % 6);
		end
		`CHK(q.size(), 0)
		test_done;
	end
endmodule // tb_top
